// ==== design/hgc_consts.svh ====
// offsets, field positions, reset values and timing of the hub control bank
`ifndef HGC_CONSTS_SVH
`define HGC_CONSTS_SVH
`define HGC_OFS_ADDR 8'h00
`define HGC_OFS_SRST 8'h01
`define HGC_OFS_GCFG 8'h02
`define HGC_OFS_DSTS 8'h04
`define HGC_ADDR_OVR_BIT 0
`define HGC_ADDR_FLD_HI 7
`define HGC_ADDR_FLD_LO 1
`define HGC_ADDR_RST 8'h00
`define HGC_SRST_KEEP_BIT 0
`define HGC_SRST_FULL_BIT 1
`define HGC_SRST_RELOAD_BIT 2
`define HGC_SRST_RST 8'h00
`define HGC_GCFG_RST 8'h1E
`define HGC_GCFG_WMASK 8'h3F
`define HGC_STS_CKSUM_BIT 7
`define HGC_STS_DONE_BIT 6
`define HGC_STS_REFCLK_BIT 4
`define HGC_ZERO_BYTE 8'h00
`define HGC_CLK_NS 4
`define HGC_RST_HOLD_NS 16
`define HGC_RST_HOLD_CYC ((`HGC_RST_HOLD_NS + `HGC_CLK_NS - 1) / `HGC_CLK_NS)
`define HGC_CNT_W 4
`endif

// ==== design/hgc_global_control_regs.sv ====
// global control register bank of the quad link deserializer hub
`timescale 1ns/100ps
`default_nettype none
`include "hgc_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - address field bits 7:1 always reads the address currently answered
// - override bit 0 clear: field read-only, shows strap-latched address
// - override bit set: field writable, written value becomes bus address
// - strap-loaded field defaults from strap pins after reset, stays writable
// - writing 1 to reset bit 2 reloads rom configuration, self-clearing
// - reload completion shows on init-done flag; host polls it
// - writing 1 to reset bit 1 resets all logic and registers, self-clears
// - writing 1 to reset bit 0 resets logic keeping registers, self-clears
// - config bit 5 enables local bus controller; resets disabled
// - policy bit 4 clear: transmit port high-z when no assigned lock
// - policy bit 4 set: per-port control; unlocked sits in lp-11 with sleep select bit 2 and drive enable bit 3 set, hs-0 with bit 2 clear
// - sleep select 1 with drive enable bit 3 clear: outputs high-z
// - sleep select bit 2 clear with lock low and policy bit 4 set: outputs forced hs-0
// - config bit 1 enables receiver parity checking; resets enabled
// - config bit 0 forces reference clock present, else detector used
// - status bit 6 set once rom configuration load has completed
module hgc_global_control_regs
  import hgc_pkg::*;
#(
  parameter int NUM_TX = 2,
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [6:0] strap_addr,
  input wire hgc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic rom_load_done,
  input wire logic rom_cksum_ok,
  input wire logic ref_clk_detect,
  input wire logic [NUM_RX-1:0] rx_lock,
  input wire logic [NUM_TX-1:0][NUM_RX-1:0] rx_assign,
  input wire hgc_tx_state_t [NUM_TX-1:0] per_port_tx_control,
  output logic [6:0] bus_address,
  output logic local_bus_ctrl_en,
  output logic parity_check_en,
  output logic ref_clock_present,
  output logic logic_reset,
  output logic rom_load_start,
  output logic init_done,
  output hgc_tx_state_t [NUM_TX-1:0] tx_state
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_addr;
  logic wr_srst;
  logic wr_gcfg;
  logic full_req;
  logic keep_req;
  logic reload_req;

  assign wr_addr = reg_req.wr && (reg_req.addr == `HGC_OFS_ADDR);
  assign wr_srst = reg_req.wr && (reg_req.addr == `HGC_OFS_SRST);
  assign wr_gcfg = reg_req.wr && (reg_req.addr == `HGC_OFS_GCFG);

  // only ones act; zeros in a write are ignored
  assign full_req = wr_srst && reg_req.wdata[`HGC_SRST_FULL_BIT];
  assign keep_req = wr_srst && reg_req.wdata[`HGC_SRST_KEEP_BIT];
  assign reload_req = wr_srst && reg_req.wdata[`HGC_SRST_RELOAD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic [6:0] strap_q;
  logic strap_taken_q;

  // strap pins sampled on the first enabled edge after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_q <= '0;
      strap_taken_q <= 1'b0;
    end else if (clk_en) begin
      if (full_req) begin
        strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
        strap_q <= strap_addr;
        strap_taken_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus address register

  logic [6:0] addr_field_q;
  logic addr_ovr_q;
  logic [7:0] addr_rst;

  assign addr_rst = `HGC_ADDR_RST;

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_ovr_q <= addr_rst[`HGC_ADDR_OVR_BIT];
    end else if (clk_en) begin
      if (full_req) begin
        addr_ovr_q <= addr_rst[`HGC_ADDR_OVR_BIT];
      end else if (wr_addr) begin
        addr_ovr_q <= reg_req.wdata[`HGC_ADDR_OVR_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_field_q <= addr_rst[`HGC_ADDR_FLD_HI:`HGC_ADDR_FLD_LO];
    end else if (clk_en) begin
      if (full_req) begin
        addr_field_q <= addr_rst[`HGC_ADDR_FLD_HI:`HGC_ADDR_FLD_LO];
      end else if (!strap_taken_q) begin
        addr_field_q <= strap_addr;
      end else if (wr_addr && reg_req.wdata[`HGC_ADDR_OVR_BIT]) begin
        // field takes writes only with override set in the same write
        addr_field_q <= reg_req.wdata[`HGC_ADDR_FLD_HI:`HGC_ADDR_FLD_LO];
      end
    end
  end

  logic [6:0] cur_addr;

  // the strap value governs while override is clear
  assign cur_addr = addr_ovr_q ? addr_field_q : strap_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_address <= '0;
    end else if (clk_en) begin
      bus_address <= cur_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general configuration register

  hgc_gcfg_t gcfg_q;
  logic [7:0] gcfg_wmask;

  assign gcfg_wmask = `HGC_GCFG_WMASK;

  always_ff @(posedge clk) begin
    if (reset) begin
      gcfg_q <= hgc_gcfg_t'(`HGC_GCFG_RST);
    end else if (clk_en) begin
      if (full_req) begin
        gcfg_q <= hgc_gcfg_t'(`HGC_GCFG_RST);
      end else if (wr_gcfg) begin
        gcfg_q <= hgc_gcfg_t'(reg_req.wdata & gcfg_wmask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs driven by the configuration

  always_ff @(posedge clk) begin
    if (reset) begin
      local_bus_ctrl_en <= 1'b0;
      parity_check_en <= 1'b0;
    end else if (clk_en) begin
      local_bus_ctrl_en <= gcfg_q.lbus_en;
      parity_check_en <= gcfg_q.parity_check_en;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_clock_present <= 1'b0;
    end else if (clk_en) begin
      ref_clock_present <= gcfg_q.ref_clock_present_override
                           | ref_clk_detect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // soft reset and rom reload

  logic full_busy;
  logic keep_busy;
  logic reload_busy;

  hgc_reload_seq u_reload_seq (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .full_req(full_req),
    .keep_req(keep_req),
    .reload_req(reload_req),
    .rom_load_done(rom_load_done),
    .logic_reset(logic_reset),
    .rom_load_start(rom_load_start),
    .init_done(init_done),
    .full_busy(full_busy),
    .keep_busy(keep_busy),
    .reload_busy(reload_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit output policy, one per csi-2 port

  hgc_tx_policy_t policy;

  assign policy.lock_loss_mode = gcfg_q.lock_loss_mode;
  assign policy.out_drive_en = gcfg_q.out_drive_en;
  assign policy.sleep_state_choice = gcfg_q.sleep_state_choice;

  for (genvar i = 0; i < NUM_TX; i++) begin : g_tx
    hgc_tx_policy #(
      .NUM_RX(NUM_RX)
    ) u_tx_policy (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .policy(policy),
      .rx_lock(rx_lock),
      .rx_assign(rx_assign[i]),
      .ctl_state(per_port_tx_control[i]),
      .tx_state(tx_state[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rd_mux;
  logic [7:0] addr_rd;
  logic [7:0] srst_rd;
  logic [7:0] sts_rd;

  always_comb begin
    addr_rd = `HGC_ZERO_BYTE;
    addr_rd[`HGC_ADDR_FLD_HI:`HGC_ADDR_FLD_LO] = cur_addr;
    addr_rd[`HGC_ADDR_OVR_BIT] = addr_ovr_q;
  end

  // self-clearing bits read one while their action is under way
  always_comb begin
    srst_rd = `HGC_SRST_RST;
    srst_rd[`HGC_SRST_KEEP_BIT] = keep_busy;
    srst_rd[`HGC_SRST_FULL_BIT] = full_busy;
    srst_rd[`HGC_SRST_RELOAD_BIT] = reload_busy;
  end

  always_comb begin
    sts_rd = `HGC_ZERO_BYTE;
    sts_rd[`HGC_STS_CKSUM_BIT] = init_done && rom_cksum_ok;
    sts_rd[`HGC_STS_DONE_BIT] = init_done;
    sts_rd[`HGC_STS_REFCLK_BIT] = ref_clock_present;
  end

  always_comb begin
    unique case (reg_req.addr)
      `HGC_OFS_ADDR: rd_mux = addr_rd;
      `HGC_OFS_SRST: rd_mux = srst_rd;
      `HGC_OFS_GCFG: rd_mux = gcfg_q;
      `HGC_OFS_DSTS: rd_mux = sts_rd;
      default: rd_mux = `HGC_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `HGC_ZERO_BYTE;
      reg_rdata_valid <= 1'b0;
    end else if (clk_en) begin
      reg_rdata_valid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule : hgc_global_control_regs
`default_nettype wire

// ==== design/hgc_pkg.sv ====
// types shared by the hub global control bank
package hgc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hgc_reg_req_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic lbus_en;
    logic lock_loss_mode;
    logic out_drive_en;
    logic sleep_state_choice;
    logic parity_check_en;
    logic ref_clock_present_override;
  } hgc_gcfg_t;

  typedef struct packed {
    logic lock_loss_mode;
    logic out_drive_en;
    logic sleep_state_choice;
  } hgc_tx_policy_t;

  typedef enum logic [1:0] {
    HGC_TX_RUN,
    HGC_TX_HIZ,
    HGC_TX_LP11,
    HGC_TX_HS0
  } hgc_tx_state_t;

  typedef enum logic [1:0] {
    HGC_SEQ_IDLE,
    HGC_SEQ_RESET,
    HGC_SEQ_LOAD
  } hgc_seq_t;
endpackage : hgc_pkg

// ==== design/hgc_reload_seq.sv ====
// soft reset pulse and rom reload sequencing with init-done flag
`timescale 1ns/100ps
`default_nettype none
`include "hgc_consts.svh"
module hgc_reload_seq
  import hgc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic full_req,
  input wire logic keep_req,
  input wire logic reload_req,
  input wire logic rom_load_done,
  output logic logic_reset,
  output logic rom_load_start,
  output logic init_done,
  output logic full_busy,
  output logic keep_busy,
  output logic reload_busy
);
  hgc_seq_t state_q;
  logic [`HGC_CNT_W-1:0] cnt_q;
  logic full_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= HGC_SEQ_LOAD;
      rom_load_start <= 1'b1;
      init_done <= 1'b0;
      cnt_q <= '0;
      full_q <= 1'b0;
    end else if (clk_en) begin
      rom_load_start <= 1'b0;
      unique case (state_q)
        HGC_SEQ_IDLE: begin
          if (full_req || keep_req) begin
            state_q <= HGC_SEQ_RESET;
            full_q <= full_req;
            cnt_q <= `HGC_CNT_W'(`HGC_RST_HOLD_CYC - 1);
          end else if (reload_req) begin
            state_q <= HGC_SEQ_LOAD;
            rom_load_start <= 1'b1;
            init_done <= 1'b0;
          end
        end
        HGC_SEQ_RESET: begin
          if (cnt_q == '0) begin
            // a full reset also reloads configuration as at power-up
            if (full_q) begin
              state_q <= HGC_SEQ_LOAD;
              rom_load_start <= 1'b1;
              init_done <= 1'b0;
            end else begin
              state_q <= HGC_SEQ_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        HGC_SEQ_LOAD: begin
          if (rom_load_done) begin
            state_q <= HGC_SEQ_IDLE;
            init_done <= 1'b1;
          end
        end
      endcase
    end
  end

  assign logic_reset = (state_q == HGC_SEQ_RESET);
  assign full_busy = logic_reset && full_q;
  assign keep_busy = logic_reset && !full_q;
  assign reload_busy = (state_q == HGC_SEQ_LOAD);
endmodule : hgc_reload_seq
`default_nettype wire

// ==== design/hgc_tx_policy.sv ====
// output state of one csi-2 transmit port from lock and policy bits
`timescale 1ns/100ps
`default_nettype none
module hgc_tx_policy
  import hgc_pkg::*;
#(
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire hgc_tx_policy_t policy,
  input wire logic [NUM_RX-1:0] rx_lock,
  input wire logic [NUM_RX-1:0] rx_assign,
  input wire hgc_tx_state_t ctl_state,
  output hgc_tx_state_t tx_state
);
  logic locked;
  hgc_tx_state_t state_d;

  assign locked = |(rx_lock & rx_assign);

  always_comb begin
    state_d = ctl_state;
    if (policy.sleep_state_choice && !policy.out_drive_en) begin
      state_d = HGC_TX_HIZ;
    end else if (!locked) begin
      if (!policy.lock_loss_mode) begin
        state_d = HGC_TX_HIZ;
      end else if (!policy.sleep_state_choice) begin
        state_d = HGC_TX_HS0;
      end else begin
        state_d = HGC_TX_LP11;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state <= HGC_TX_HIZ;
    end else if (clk_en) begin
      tx_state <= state_d;
    end
  end
endmodule : hgc_tx_policy
`default_nettype wire

// ==== sim/hgc_chk_assertions.sv ====
// port checker for the hub global control bank
`timescale 1ns/100ps
`default_nettype none
module hgc_chk
  import hgc_pkg::*;
#(
  parameter int NUM_TX = 2,
  parameter int NUM_RX = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [6:0] strap_addr,
  input wire hgc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  input wire logic rom_load_done,
  input wire logic ref_clk_detect,
  input wire logic [NUM_RX-1:0] rx_lock,
  input wire logic [6:0] bus_address,
  input wire logic local_bus_ctrl_en,
  input wire logic parity_check_en,
  input wire logic ref_clock_present,
  input wire logic logic_reset,
  input wire logic rom_load_start,
  input wire logic init_done,
  input wire hgc_tx_state_t [NUM_TX-1:0] tx_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !clk_en);
  logic wa0;
  logic wa1;
  logic wa2;
  assign wa0 = reg_req.wr && reg_req.addr == 8'h00;
  assign wa1 = reg_req.wr && reg_req.addr == 8'h01;
  assign wa2 = reg_req.wr && reg_req.addr == 8'h02;
  property p_unmapped;
    reg_req.rd && reg_req.addr == 8'h03
      |=> reg_rdata_valid && reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_addr_ovr;
    wa0 && reg_req.wdata[0] |=> ##1
      bus_address == $past(reg_req.wdata[7:1], 2);
  endproperty
  a_addr_ovr: assert property (p_addr_ovr)
    else $error("written address not taken");
  property p_addr_strap;
    wa0 && !reg_req.wdata[0] |=> ##1 bus_address == strap_addr;
  endproperty
  a_addr_strap: assert property (p_addr_strap)
    else $error("address not strapped");
  property p_lbus;
    wa2 |=> ##1 local_bus_ctrl_en == $past(reg_req.wdata[5], 2);
  endproperty
  a_lbus: assert property (p_lbus)
    else $error("bus controller enable wrong");
  property p_parity;
    wa2 |=> ##1 parity_check_en == $past(reg_req.wdata[1], 2);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity enable wrong");
  property p_refclk;
    ref_clk_detect |=> ref_clock_present;
  endproperty
  a_refclk: assert property (p_refclk)
    else $error("detected clock not reported");
  property p_soft_rst;
    wa1 && reg_req.wdata[1:0] != 2'b00 && init_done && !logic_reset
      |=> logic_reset [*4] ##1 !logic_reset;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset pulse wrong");
  property p_load_clr;
    rom_load_start |=> !init_done;
  endproperty
  a_load_clr: assert property (p_load_clr)
    else $error("init done kept during load");
  property p_done;
    $rose(rom_load_done) |=> init_done;
  endproperty
  a_done: assert property (p_done)
    else $error("init done not set");
  property p_unlocked;
    rx_lock == '0 |=> tx_state[0] != HGC_TX_RUN && tx_state[1] != HGC_TX_RUN;
  endproperty
  a_unlocked: assert property (p_unlocked)
    else $error("unlocked port still running");
endmodule : hgc_chk
bind hgc_global_control_regs hgc_chk #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX)) chk (
  .clk, .reset, .clk_en, .strap_addr, .reg_req, .reg_rdata, .reg_rdata_valid,
  .rom_load_done, .ref_clk_detect, .rx_lock, .bus_address, .local_bus_ctrl_en,
  .parity_check_en, .ref_clock_present, .logic_reset, .rom_load_start,
  .init_done, .tx_state
);
`default_nettype wire

// ==== sim/hgc_host.sv ====
// host controller model issuing register cycles
`timescale 1ns/100ps
`default_nettype none
`include "hgc_consts.svh"
module hgc_host
  import hgc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  output hgc_reg_req_t reg_req
);
  int gap = 0;
  initial reg_req = '0;
  task automatic xfer(input bit w, input logic [7:0] a, d,
    output logic [7:0] q);
    q = 8'hXX;
    repeat (gap) @(negedge clk);
    @(negedge clk);
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    // released lines show garbage, not the last value
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    if (!w && reg_rdata_valid === 1'b1)
      q = reg_rdata;
  endtask : xfer
  task automatic poll_done(output bit ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      xfer(1'b0, `HGC_OFS_DSTS, 8'h00, s);
      ok = s[`HGC_STS_DONE_BIT] === 1'b1;
    end
  endtask : poll_done
endmodule : hgc_host
`default_nettype wire

// ==== sim/hub_global_control_regs_bench.sv ====
// self-checking bench for the hub global control bank
`timescale 1ns/100ps
`default_nettype none
`include "hgc_consts.svh"
module hub_global_control_regs_bench
  import hgc_pkg::*;
;
  localparam logic [6:0] STRAP = 7'h3A;
  localparam hgc_tx_state_t [1:0] CTL = '{HGC_TX_HS0, HGC_TX_RUN};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic ref_clk_detect = 1'b0;
  logic rom_load_done = 1'b0;
  logic [3:0] rx_lock = 4'h0;
  logic [2:0] ld_cnt = 3'h0;
  hgc_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic [7:0] q;
  logic reg_rdata_valid, rom_load_start, logic_reset, init_done;
  logic local_bus_ctrl_en, parity_check_en, ref_clock_present;
  logic [6:0] bus_address;
  hgc_tx_state_t [1:0] tx_state;
  bit ok;
  int err_total = 0;
  int compares = 0;
  always #2 clk = ~clk;
  hgc_global_control_regs uut (.clk(clk), .reset(reset), .clk_en(clk_en),
    .strap_addr(STRAP), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .rom_load_done(rom_load_done),
    .rom_cksum_ok(1'b1), .ref_clk_detect(ref_clk_detect), .rx_lock(rx_lock),
    .rx_assign(8'hFF), .per_port_tx_control(CTL), .bus_address(bus_address),
    .local_bus_ctrl_en(local_bus_ctrl_en), .parity_check_en(parity_check_en),
    .ref_clock_present(ref_clock_present), .logic_reset(logic_reset),
    .rom_load_start(rom_load_start), .init_done(init_done),
    .tx_state(tx_state));
  hgc_host host (.clk(clk), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .reg_req(reg_req));
  // rom loader answers a start after six cycles
  always @(negedge clk) begin
    rom_load_done <= ld_cnt == 3'h1;
    ld_cnt <= rom_load_start ? 3'h6 : ld_cnt - {2'b00, ld_cnt != 3'h0};
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic t_power;
    host.poll_done(ok);
    chk({7'h00, ok}, 8'h01);
    rd(`HGC_OFS_DSTS, 8'hC0);
    rd(`HGC_OFS_ADDR, {STRAP, 1'b0});
    rd(`HGC_OFS_SRST, `HGC_SRST_RST);
    rd(`HGC_OFS_GCFG, `HGC_GCFG_RST);
    chk({6'h00, local_bus_ctrl_en, parity_check_en}, 8'h01);
    $display("power-up test done");
  endtask : t_power
  task automatic t_addr;
    wr(`HGC_OFS_ADDR, 8'hAA);
    rd(`HGC_OFS_ADDR, {STRAP, 1'b0});
    wr(`HGC_OFS_ADDR, 8'h55);
    rd(`HGC_OFS_ADDR, 8'h55);
    chk({1'b0, bus_address}, 8'h2A);
    wr(`HGC_OFS_ADDR, 8'h00);
    rd(`HGC_OFS_ADDR, {STRAP, 1'b0});
    chk({1'b0, bus_address}, {1'b0, STRAP});
    $display("address test done");
  endtask : t_addr
  task automatic t_gcfg;
    wr(`HGC_OFS_GCFG, 8'hFF);
    rd(`HGC_OFS_GCFG, 8'h3F);
    chk({5'h00, local_bus_ctrl_en, parity_check_en, ref_clock_present},
      8'h07);
    wr(`HGC_OFS_GCFG, 8'h00);
    ref_clk_detect = 1'b1;
    rd(8'h03, 8'h00);
    chk({5'h00, local_bus_ctrl_en, parity_check_en, ref_clock_present},
      8'h01);
    ref_clk_detect = 1'b0;
    // presence flag is registered: let it settle before the status read
    @(negedge clk);
    rd(`HGC_OFS_DSTS, 8'hC0);
    $display("config test done");
  endtask : t_gcfg
  task automatic t_tx;
    logic [7:0] cfg [5] = '{8'h00, 8'h10, 8'h14, 8'h1C, 8'h00};
    logic [3:0] lk [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
    hgc_tx_state_t ex [5] = '{HGC_TX_HIZ, HGC_TX_HS0, HGC_TX_HIZ,
      HGC_TX_LP11, HGC_TX_RUN};
    for (int i = 0; i < 5; i++) begin
      rx_lock = lk[i];
      wr(`HGC_OFS_GCFG, cfg[i]);
      rd(`HGC_OFS_GCFG, cfg[i]);
      chk({6'h00, tx_state[0]}, {6'h00, ex[i]});
    end
    rx_lock = 4'h0;
    $display("transmit policy test done");
  endtask : t_tx
  task automatic t_keep;
    host.gap = 3;
    wr(`HGC_OFS_GCFG, 8'h2A);
    wr(`HGC_OFS_SRST, 8'h01);
    chk({7'h00, logic_reset}, 8'h01);
    host.gap = 0;
    repeat (8) @(negedge clk);
    rd(`HGC_OFS_GCFG, 8'h2A);
    rd(`HGC_OFS_SRST, 8'h00);
    wr(`HGC_OFS_SRST, 8'h00);
    chk({6'h00, logic_reset, init_done}, 8'h01);
    $display("keep-register reset test done");
  endtask : t_keep
  task automatic t_full;
    wr(`HGC_OFS_ADDR, 8'h55);
    wr(`HGC_OFS_SRST, 8'h02);
    repeat (8) @(negedge clk);
    chk({7'h00, init_done}, 8'h00);
    host.poll_done(ok);
    chk({7'h00, ok}, 8'h01);
    rd(`HGC_OFS_GCFG, `HGC_GCFG_RST);
    rd(`HGC_OFS_ADDR, {STRAP, 1'b0});
    rd(`HGC_OFS_SRST, 8'h00);
    $display("full reset test done");
  endtask : t_full
  task automatic t_reload;
    wr(`HGC_OFS_SRST, 8'h04);
    rd(`HGC_OFS_SRST, 8'h04);
    host.poll_done(ok);
    chk({7'h00, ok}, 8'h01);
    rd(`HGC_OFS_SRST, 8'h00);
    $display("reload test done");
  endtask : t_reload
  task automatic t_freeze;
    clk_en = 1'b0;
    wr(`HGC_OFS_GCFG, 8'h00);
    wr(`HGC_OFS_SRST, 8'h02);
    chk({7'h00, logic_reset}, 8'h00);
    clk_en = 1'b1;
    rd(`HGC_OFS_GCFG, `HGC_GCFG_RST);
    $display("clock enable test done");
  endtask : t_freeze
  task automatic results;
    $display("%0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_power();
    t_addr();
    t_gcfg();
    t_tx();
    t_keep();
    t_full();
    t_reload();
    t_freeze();
    results();
  end
  initial begin
    #40000;
    err_total++;
    results();
  end
endmodule : hub_global_control_regs_bench
`default_nettype wire
